// ===== design/sdi_top.sv
// Servo digital input function decoder and motion control gating
`timescale 1ns/1ps
// Overview of operation
// - Travel limits block further motion that way
// - Stop contact brings the motor to stop
// - Proportional-only contact selects P control
// - Gain switch contact selects second gain set
// - Forward clamp contact enables forward torque limit
// - Reverse clamp contact enables reverse torque limit
// - Two probes latch position into own slots
// - Emergency input stops and raises warning 80
// - Emergency stop method follows configuration value
// - Enable energises motor, disable frees it
// - Alarm clear input clears the alarm
// - Index run starts selected move in index mode
// - Post sensor switches to preset speed, distance
// - Homing run starts homing in index mode using origin sensor
// - Six select bits form index 0 to 63
// - Hold during index move decelerates to stop
// - Second hold resumes interrupted index move
// - Absolute request sends position as quadrature
// - Jog run drives jog at configured speed
// - Enable ignored for two seconds after power
module sdi_top
  import sdi_pkg::*;
#(
  parameter int unsigned POWERUP_CNT = POWERUP_CYCLES,
  parameter int unsigned ABS_DIV     = ABS_DIV_DEFAULT
)
(
  input  wire logic               CLK,
  input  wire logic               SRST,
  input  wire sdi_contacts_t      CONTACTS,
  input  wire logic               INDEX_MODE,
  input  wire logic               REG_INDEX_TYPE,
  input  wire logic [1:0]         EMG_STOP_METHOD,
  input  wire logic               ALARM_IN,
  input  wire logic [POS_W-1:0]   POSITION,
  input  wire logic [POS_W-1:0]   ABS_POSITION,
  input  wire logic               MOVE_DONE,
  output logic                    MOTOR_ENABLE,
  output logic                    FREE_RUN,
  output logic                    FWD_INHIBIT,
  output logic                    REV_INHIBIT,
  output logic                    STOP_CMD,
  output logic                    DECEL_STOP,
  output logic [1:0]              EMG_METHOD,
  output logic [7:0]              WARNING_CODE,
  output logic                    P_ONLY,
  output logic                    SECOND_GAIN_SELECT_SEL,
  output logic                    FWD_TORQUE_LIMIT,
  output logic                    REV_TORQUE_LIMIT,
  output logic [POS_W-1:0]        TOUCH_PROBE_ONE_POS,
  output logic [POS_W-1:0]        TOUCH_PROBE_TWO_POS,
  output logic                    TOUCH_PROBE_ONE_VALID,
  output logic                    TOUCH_PROBE_TWO_VALID,
  output logic                    ALARM_ACTIVE,
  output logic [INDEX_W-1:0]      INDEX_NUM,
  output logic                    INDEX_START,
  output logic                    INDEX_ACTIVE,
  output logic                    INDEX_HELD,
  output logic                    REG_SWITCH,
  output logic                    HOMING_ACTIVE,
  output logic                    HOME_REF,
  output logic                    JOG_ACTIVE,
  output logic                    ENC_A,
  output logic                    ENC_B,
  output logic                    ABS_BUSY
);

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    sdi_contacts_t       sync1;
    sdi_contacts_t       sync2;
    sdi_contacts_t       prev;
    logic [31:0]         pwr_cnt;
    logic                pwr_ok;
    sdi_state_t          st;
    logic                alarm;
    logic [POS_W-1:0]    p1;
    logic [POS_W-1:0]    p2;
    logic                p1v;
    logic                p2v;
    logic                start_p;
    logic                reg_sw;
    sdi_abs_t            ab;
    logic [POS_W-1:0]    ab_shift;
    logic [5:0]          ab_left;
    logic [DIV_W-1:0]    ab_div;
    logic [1:0]          quad;
    logic                ab_phase;
    logic [7:0]          warn;
  } sdi_state_rec_t;

  sdi_state_rec_t s_reg;
  sdi_state_rec_t s_next;

  // Gray sequence step for quadrature output
  function automatic logic [1:0] quad_step(input logic [1:0] q);
    quad_step = {q[0], ~q[1]};
  endfunction

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  sdi_contacts_t c;
  sdi_contacts_t p;
  logic          enable_ok;

  always_comb
  begin
    s_next = s_reg;
    c = s_reg.sync2;
    p = s_reg.prev;
    s_next.sync1 = CONTACTS;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = c;
    s_next.start_p = 1'b0;

    // Power-up guard on servo enable
    if (!s_reg.pwr_ok)
    begin
      if (s_reg.pwr_cnt >= POWERUP_CNT - 1)
      begin
        s_next.pwr_ok = 1'b1;
      end
      else
      begin
        s_next.pwr_cnt = s_reg.pwr_cnt + 32'h1;
      end
    end
    enable_ok = s_reg.pwr_ok & c.servo_enable_input;

    // Alarm latch: a new alarm wins over a clear
    if (ALARM_IN)
    begin
      s_next.alarm = 1'b1;
    end
    else if (c.alarm_clr)
    begin
      s_next.alarm = 1'b0;
    end

    // Emergency warning held while contact is on
    s_next.warn = c.emergency_halt_input ? WARN_EMERGENCY : WARN_NONE;

    // Probe latches on rising edge, one slot each
    if (rise(c.touch_probe_one, p.touch_probe_one))
    begin
      s_next.p1 = POSITION;
      s_next.p1v = 1'b1;
    end
    if (rise(c.touch_probe_two, p.touch_probe_two))
    begin
      s_next.p2 = POSITION;
      s_next.p2v = 1'b1;
    end

    // Post sensor switch only for registration index types
    if (s_reg.st == ST_INDEX && REG_INDEX_TYPE && rise(c.post_sensor, p.post_sensor))
    begin
      s_next.reg_sw = 1'b1;
    end

    // Motion sequencer
    case (s_reg.st)
      ST_OFF:
      begin
        if (enable_ok && !s_reg.alarm && !c.emergency_halt_input)
        begin
          s_next.st = ST_READY;
        end
      end
      ST_READY:
      begin
        if (INDEX_MODE && rise(c.idx_run, p.idx_run))
        begin
          s_next.st = ST_INDEX;
          s_next.start_p = 1'b1;
          s_next.reg_sw = 1'b0;
        end
        else if (INDEX_MODE && rise(c.home_run, p.home_run))
        begin
          s_next.st = ST_HOME;
        end
        else if (c.jog_run)
        begin
          s_next.st = ST_JOG;
        end
      end
      ST_INDEX:
      begin
        if (rise(c.hold, p.hold))
        begin
          s_next.st = ST_HELD;
        end
        else if (MOVE_DONE)
        begin
          s_next.st = ST_READY;
          s_next.reg_sw = 1'b0;
        end
      end
      ST_HELD:
      begin
        if (rise(c.hold, p.hold))
        begin
          s_next.st = ST_INDEX;
        end
      end
      ST_HOME:
      begin
        if (MOVE_DONE)
        begin
          s_next.st = ST_READY;
        end
      end
      ST_JOG:
      begin
        if (!c.jog_run)
        begin
          s_next.st = ST_READY;
        end
      end
      default:
      begin
        s_next.st = ST_OFF;
      end
    endcase

    // Loss of enable, alarm or emergency overrides any motion
    if (!enable_ok || s_reg.alarm || c.emergency_halt_input)
    begin
      s_next.st = ST_OFF;
      s_next.reg_sw = 1'b0;
    end

    // Absolute position as quadrature, one edge per divided tick
    case (s_reg.ab)
      AB_IDLE:
      begin
        if (rise(c.abs_req, p.abs_req))
        begin
          s_next.ab = AB_SEND;
          s_next.ab_shift = ABS_POSITION;
          s_next.ab_left = ABS_BITS_DEFAULT;
          s_next.ab_div = '0;
          s_next.ab_phase = 1'b0;
        end
      end
      AB_SEND:
      begin
        if (s_reg.ab_div == DIV_W'(ABS_DIV - 1))
        begin
          s_next.ab_div = '0;
          // Each data bit is one quadrature edge; bit value picks direction
          s_next.quad = s_reg.ab_shift[0] ? quad_step(s_reg.quad)
                                          : {~s_reg.quad[0], s_reg.quad[1]};
          s_next.ab_shift = s_reg.ab_shift >> 1;
          s_next.ab_left = s_reg.ab_left - 6'h1;
          if (s_reg.ab_left == 6'h1)
          begin
            s_next.ab = AB_DONE;
          end
        end
        else
        begin
          s_next.ab_div = s_reg.ab_div + DIV_W'(1);
        end
      end
      AB_DONE:
      begin
        if (!c.abs_req)
        begin
          s_next.ab = AB_IDLE;
        end
      end
      default:
      begin
        s_next.ab = AB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      s_reg <= '0;
      s_reg.st <= ST_OFF;
      s_reg.ab <= AB_IDLE;
      s_reg.quad <= QUAD_RESET;
      s_reg.p1 <= POS_RESET;
      s_reg.p2 <= POS_RESET;
      s_reg.ab_left <= PASS_RESET;
      s_reg.warn <= WARN_NONE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      MOTOR_ENABLE     <= 1'b0;
      FREE_RUN         <= 1'b1;
      FWD_INHIBIT      <= 1'b0;
      REV_INHIBIT      <= 1'b0;
      STOP_CMD         <= 1'b0;
      DECEL_STOP       <= 1'b0;
      EMG_METHOD       <= 2'h0;
      WARNING_CODE     <= WARN_NONE;
      P_ONLY           <= 1'b0;
      SECOND_GAIN_SELECT_SEL        <= 1'b0;
      FWD_TORQUE_LIMIT <= 1'b0;
      REV_TORQUE_LIMIT <= 1'b0;
      TOUCH_PROBE_ONE_POS       <= POS_RESET;
      TOUCH_PROBE_TWO_POS       <= POS_RESET;
      TOUCH_PROBE_ONE_VALID     <= 1'b0;
      TOUCH_PROBE_TWO_VALID     <= 1'b0;
      ALARM_ACTIVE     <= 1'b0;
      INDEX_NUM        <= '0;
      INDEX_START      <= 1'b0;
      INDEX_ACTIVE     <= 1'b0;
      INDEX_HELD       <= 1'b0;
      REG_SWITCH       <= 1'b0;
      HOMING_ACTIVE    <= 1'b0;
      HOME_REF         <= 1'b0;
      JOG_ACTIVE       <= 1'b0;
      ENC_A            <= 1'b0;
      ENC_B            <= 1'b0;
      ABS_BUSY         <= 1'b0;
    end
    else
    begin
      MOTOR_ENABLE     <= s_reg.st != ST_OFF;
      FREE_RUN         <= s_reg.st == ST_OFF;
      FWD_INHIBIT      <= s_reg.sync2.fwd_limit;
      REV_INHIBIT      <= s_reg.sync2.rev_limit;
      STOP_CMD         <= s_reg.sync2.stop | s_reg.sync2.emergency_halt_input;
      DECEL_STOP       <= s_reg.st == ST_HELD;
      EMG_METHOD       <= EMG_STOP_METHOD;
      WARNING_CODE     <= s_reg.warn;
      P_ONLY           <= s_reg.sync2.p_only;
      SECOND_GAIN_SELECT_SEL        <= s_reg.sync2.second_gain_select;
      FWD_TORQUE_LIMIT <= s_reg.sync2.fwd_clamp;
      REV_TORQUE_LIMIT <= s_reg.sync2.rev_clamp;
      TOUCH_PROBE_ONE_POS       <= s_reg.p1;
      TOUCH_PROBE_TWO_POS       <= s_reg.p2;
      TOUCH_PROBE_ONE_VALID     <= s_reg.p1v;
      TOUCH_PROBE_TWO_VALID     <= s_reg.p2v;
      ALARM_ACTIVE     <= s_reg.alarm;
      INDEX_NUM        <= s_reg.sync2.idx_sel;
      INDEX_START      <= s_reg.start_p & (s_reg.st == ST_INDEX);
      INDEX_ACTIVE     <= s_reg.st == ST_INDEX;
      INDEX_HELD       <= s_reg.st == ST_HELD;
      REG_SWITCH       <= s_reg.reg_sw;
      HOMING_ACTIVE    <= s_reg.st == ST_HOME;
      HOME_REF         <= s_reg.sync2.origin;
      JOG_ACTIVE       <= s_reg.st == ST_JOG;
      ENC_A            <= s_reg.quad[1];
      ENC_B            <= s_reg.quad[0];
      ABS_BUSY         <= s_reg.ab == AB_SEND;
    end
  end

endmodule

// ===== pkg/sdi_pkg.sv
// Package for the servo digital input function decoder
package sdi_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned POWERUP_HOLD_S  = 2;
  localparam int unsigned POWERUP_CYCLES  = POWERUP_HOLD_S * CLK_HZ;
  localparam int unsigned POS_W           = 32;
  localparam int unsigned INDEX_W         = 6;
  localparam int unsigned DIV_W           = 8;
  localparam int unsigned ABS_DIV_DEFAULT = 16;

  // ----------------------------------------
  // Encodings and reset values
  // ----------------------------------------
  localparam logic [7:0]       WARN_EMERGENCY   = 8'h80;
  localparam logic [7:0]       WARN_NONE        = 8'h00;
  localparam logic [1:0]       QUAD_RESET       = 2'h0;
  localparam logic [POS_W-1:0] POS_RESET        = 32'h0000_0000;
  localparam logic [5:0]       PASS_RESET       = 6'h00;
  localparam logic [5:0]       ABS_BITS_DEFAULT = 6'h20;

  // Contact inputs, in one bundle
  typedef struct packed {
    logic                   fwd_limit;
    logic                   rev_limit;
    logic                   origin;
    logic                   stop;
    logic                   p_only;
    logic                   second_gain_select;
    logic                   fwd_clamp;
    logic                   rev_clamp;
    logic                   touch_probe_one;
    logic                   touch_probe_two;
    logic                   emergency_halt_input;
    logic                   alarm_clr;
    logic                   servo_enable_input;
    logic                   idx_run;
    logic                   post_sensor;
    logic                   home_run;
    logic [INDEX_W-1:0]     idx_sel;
    logic                   hold;
    logic                   abs_req;
    logic                   jog_run;
  } sdi_contacts_t;

  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_READY = 6'h02,
    ST_INDEX = 6'h04,
    ST_HELD  = 6'h08,
    ST_HOME  = 6'h10,
    ST_JOG   = 6'h20
  } sdi_state_t;

  typedef enum logic [2:0] {
    AB_IDLE = 3'h1,
    AB_SEND = 3'h2,
    AB_DONE = 3'h4
  } sdi_abs_t;

endpackage

// ===== verification/sdi_assertions.sv
// Port timing checker for the digital input function decoder
`timescale 1ns/1ps
module sdi_assertions
  import sdi_pkg::*;
#(
  parameter int unsigned POWERUP_CNT = POWERUP_CYCLES
)
(
  input wire logic                CLK,
  input wire logic                SRST,
  input wire sdi_contacts_t       CONTACTS,
  input wire logic [1:0]          EMG_STOP_METHOD,
  input wire logic [POS_W-1:0]    POSITION,
  input wire logic                MOTOR_ENABLE,
  input wire logic                FREE_RUN,
  input wire logic                FWD_INHIBIT,
  input wire logic                REV_INHIBIT,
  input wire logic                STOP_CMD,
  input wire logic [1:0]          EMG_METHOD,
  input wire logic [7:0]          WARNING_CODE,
  input wire logic [INDEX_W-1:0]  INDEX_NUM,
  input wire logic                INDEX_START,
  input wire logic                INDEX_ACTIVE,
  input wire logic [POS_W-1:0]    TOUCH_PROBE_ONE_POS
);
  logic [2:0]  rel_reg;
  logic [31:0] up_reg;
  logic        warm;
  assign warm = (rel_reg == 3'h7);
  // Age since reset keeps $past away from samples taken before release
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rel_reg <= 3'h0;
      up_reg  <= 32'h0;
    end
    else
    begin
      rel_reg <= warm ? rel_reg : rel_reg + 3'h1;
      up_reg  <= (&up_reg) ? up_reg : up_reg + 32'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_fwd_limit: assert property (warm |-> FWD_INHIBIT == $past(CONTACTS.fwd_limit, 3))
    else $error("forward inhibit does not follow its contact");
  a_rev_limit: assert property (warm |-> REV_INHIBIT == $past(CONTACTS.rev_limit, 3))
    else $error("reverse inhibit does not follow its contact");
  a_stop_follow: assert property (warm |->
    STOP_CMD == ($past(CONTACTS.stop, 3) | $past(CONTACTS.emergency_halt_input, 3)))
    else $error("stop command does not follow stop contacts");
  a_warn_code: assert property (warm |->
    WARNING_CODE == ($past(CONTACTS.emergency_halt_input, 4) ? WARN_EMERGENCY : WARN_NONE))
    else $error("warning code wrong for emergency contact");
  a_emg_method: assert property ((warm && $stable(EMG_STOP_METHOD))[*3] |->
    EMG_METHOD == EMG_STOP_METHOD)
    else $error("emergency method not forwarded");
  a_free_run: assert property (MOTOR_ENABLE != FREE_RUN)
    else $error("enable and free run not complementary");
  a_powerup_hold: assert property (MOTOR_ENABLE |-> up_reg >= POWERUP_CNT)
    else $error("motor enabled before power-up delay");
  a_index_num: assert property (warm |-> INDEX_NUM == $past(CONTACTS.idx_sel, 3))
    else $error("index number does not follow select bits");
  a_start_pulse: assert property (INDEX_START |-> INDEX_ACTIVE ##1 !INDEX_START)
    else $error("index start not a single pulse into index state");
  a_probe_latch: assert property (warm && $past(CONTACTS.touch_probe_one, 4) &&
    !$past(CONTACTS.touch_probe_one, 5) |-> TOUCH_PROBE_ONE_POS == $past(POSITION, 2))
    else $error("first probe did not latch position");
  c_index: cover property (INDEX_START);
  c_enable: cover property ($rose(MOTOR_ENABLE));
  c_emg: cover property ($rose(WARNING_CODE[7]));
endmodule

bind sdi_top sdi_assertions #(.POWERUP_CNT(POWERUP_CNT)) u_chk (
  .CLK(CLK), .SRST(SRST), .CONTACTS(CONTACTS), .EMG_STOP_METHOD(EMG_STOP_METHOD),
  .POSITION(POSITION), .MOTOR_ENABLE(MOTOR_ENABLE), .FREE_RUN(FREE_RUN),
  .FWD_INHIBIT(FWD_INHIBIT), .REV_INHIBIT(REV_INHIBIT), .STOP_CMD(STOP_CMD),
  .EMG_METHOD(EMG_METHOD), .WARNING_CODE(WARNING_CODE), .INDEX_NUM(INDEX_NUM),
  .INDEX_START(INDEX_START), .INDEX_ACTIVE(INDEX_ACTIVE), .TOUCH_PROBE_ONE_POS(TOUCH_PROBE_ONE_POS));

// ===== verification/sdi_partner.sv
// Upper controller model that rebuilds the absolute word from quadrature
`timescale 1ns/1ps
module sdi_partner
  import sdi_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           enc_a,
  input  wire logic           enc_b,
  output logic [POS_W-1:0]    abs_word
);
  logic [1:0] prev_reg;
  logic       fwd;
  // B leading A reads as a one, A leading B as a zero
  assign fwd = ({prev_reg, enc_a, enc_b} == 4'h1) || ({prev_reg, enc_a, enc_b} == 4'h7) ||
               ({prev_reg, enc_a, enc_b} == 4'he) || ({prev_reg, enc_a, enc_b} == 4'h8);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev_reg <= QUAD_RESET;
      abs_word <= POS_RESET;
    end
    else
    begin
      prev_reg <= {enc_a, enc_b};
      if ({enc_a, enc_b} != prev_reg)
        abs_word <= {fwd, abs_word[POS_W-1:1]};
    end
  end
endmodule

// ===== verification/tb_sdi_top.sv
// Self-checking bench for the digital input function decoder
`timescale 1ns/1ps
`define CHK(n, e, o) begin total_checks++; if ((o) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, o); end end
module tb_sdi_top
  import sdi_pkg::*;
;
  typedef struct {
    string       nm;
    logic [31:0] e;
    int          at;
  } sdi_note_t;
  localparam int LIMIT = 3000;
  logic          clk = 1'h0;
  logic          srst = 1'h1;
  sdi_contacts_t c = '0;
  logic          imode = 1'h0, rtype = 1'h0, alarm = 1'h0, done = 1'h0;
  logic [1:0]    meth = 2'h0;
  logic [31:0]   pos = 32'h0, apos = 32'h0, rs = 32'hbe85;
  int            cyc = 0, fails = 0, total_checks = 0;
  sdi_note_t     q[$];
  logic          me, fr, fi, ri, sc, po, g2, ft, rt, ia, ih, rsw, ha, hr, ja, ea, eb, al;
  logic          ds, v1, v2, bz;
  logic [1:0]    em;
  logic [7:0]    wc;
  logic [5:0]    inum;
  logic [31:0]   p1, p2, aw;
  initial forever #2 clk = ~clk;
  sdi_top #(.POWERUP_CNT(20), .ABS_DIV(2)) dut (
    .CLK(clk), .SRST(srst), .CONTACTS(c), .INDEX_MODE(imode), .REG_INDEX_TYPE(rtype),
    .EMG_STOP_METHOD(meth), .ALARM_IN(alarm), .POSITION(pos), .ABS_POSITION(apos),
    .MOVE_DONE(done), .MOTOR_ENABLE(me), .FREE_RUN(fr), .FWD_INHIBIT(fi), .REV_INHIBIT(ri),
    .STOP_CMD(sc), .DECEL_STOP(ds), .EMG_METHOD(em), .WARNING_CODE(wc), .P_ONLY(po),
    .SECOND_GAIN_SELECT_SEL(g2), .FWD_TORQUE_LIMIT(ft), .REV_TORQUE_LIMIT(rt), .TOUCH_PROBE_ONE_POS(p1),
    .TOUCH_PROBE_TWO_POS(p2), .TOUCH_PROBE_ONE_VALID(v1), .TOUCH_PROBE_TWO_VALID(v2), .ALARM_ACTIVE(al), .INDEX_NUM(inum),
    .INDEX_START(), .INDEX_ACTIVE(ia), .INDEX_HELD(ih), .REG_SWITCH(rsw),
    .HOMING_ACTIVE(ha), .HOME_REF(hr), .JOG_ACTIVE(ja), .ENC_A(ea), .ENC_B(eb), .ABS_BUSY(bz));
  sdi_partner u_host (.clk(clk), .srst(srst), .enc_a(ea), .enc_b(eb), .abs_word(aw));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] obs(string n);
    case (n)
      "levels": return {8'h0, fi, ri, sc, po, g2, ft, rt, hr, inum, wc, em};
      "motor":  return {30'h0, fr, me};
      "index":  return {29'h0, ds, ih, ia};
      "probev": return {30'h0, v2, v1};
      "absb":   return {31'h0, bz};
      "regsw":  return {31'h0, rsw};
      "home":   return {31'h0, ha};
      "jog":    return {31'h0, ja};
      "alarm":  return {31'h0, al};
      "touch_probe_one": return p1;
      "touch_probe_two": return p2;
      default:  return aw;
    endcase
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(string n, logic [31:0] e, int d);
    q.push_back('{n, e, cyc + d});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Oldest note is compared once its cycle has come, outputs settled
  always @(negedge clk)
  begin
    if (q.size() > 0 && q[0].at <= cyc)
    begin
      `CHK(q[0].nm, q[0].e, obs(q[0].nm))
      void'(q.pop_front());
    end
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [31:0] s;
    tick(12);
    srst <= 1'h0;
    c.servo_enable_input <= 1'h1;
    note("motor", 32'h2, 6);
    note("motor", 32'h1, 30);
    tick(36);
    $display("test powerup ended");
    repeat (12)
    begin
      r = rnd();
      @(posedge clk);
      {c.fwd_limit, c.rev_limit, c.origin, c.stop, c.p_only, c.second_gain_select, c.fwd_clamp,
        c.rev_clamp, c.emergency_halt_input, c.idx_sel} <= r[14:0];
      meth <= r[16:15];
      note("levels", {8'h0, r[14:13], r[11] | r[6], r[10:7], r[12], r[5:0],
        r[6] ? WARN_EMERGENCY : WARN_NONE, r[16:15]}, 6);
      note("motor", r[6] ? 32'h2 : 32'h1, 7);
      tick(8);
    end
    c <= '{servo_enable_input: 1'h1, alarm_clr: 1'h1, default: '0};
    alarm <= 1'h1;
    note("alarm", 32'h1, 6);
    note("motor", 32'h2, 7);
    tick(8);
    alarm <= 1'h0;
    c.alarm_clr <= 1'h1;
    note("alarm", 32'h0, 6);
    tick(8);
    c.alarm_clr <= 1'h0;
    note("motor", 32'h1, 6);
    tick(8);
    $display("test levels and alarm ended");
    c.idx_run <= 1'h1;
    note("index", 32'h0, 6);
    tick(8);
    c.idx_run <= 1'h0;
    imode <= 1'h1;
    rtype <= 1'h1;
    tick(4);
    c.idx_run <= 1'h1;
    note("index", 32'h1, 6);
    tick(8);
    c.post_sensor <= 1'h1;
    note("regsw", 32'h1, 6);
    tick(8);
    c.hold <= 1'h1;
    note("index", 32'h6, 6);
    tick(8);
    c.hold <= 1'h0;
    tick(4);
    c.hold <= 1'h1;
    note("index", 32'h1, 6);
    tick(8);
    c.hold <= 1'h0;
    done <= 1'h1;
    note("index", 32'h0, 6);
    note("regsw", 32'h0, 7);
    tick(8);
    done <= 1'h0;
    $display("test index ended");
    c.idx_run <= 1'h0;
    c.post_sensor <= 1'h0;
    c.home_run <= 1'h1;
    note("home", 32'h1, 6);
    tick(8);
    c.home_run <= 1'h0;
    done <= 1'h1;
    note("home", 32'h0, 6);
    tick(8);
    done <= 1'h0;
    c.jog_run <= 1'h1;
    note("jog", 32'h1, 6);
    tick(8);
    c.jog_run <= 1'h0;
    note("jog", 32'h0, 6);
    tick(8);
    $display("test homing and jog ended");
    s = rnd();
    pos <= s;
    c.touch_probe_one <= 1'h1;
    note("touch_probe_one", s, 6);
    note("probev", 32'h1, 6);
    tick(8);
    r = rnd();
    pos <= r;
    c.touch_probe_two <= 1'h1;
    note("touch_probe_two", r, 6);
    note("touch_probe_one", s, 7);
    note("probev", 32'h3, 8);
    tick(8);
    $display("test probes ended");
    r = rnd();
    apos <= r;
    tick(2);
    c.abs_req <= 1'h1;
    note("absb", 32'h1, 30);
    note("abs", r, 110);
    note("absb", 32'h0, 111);
    tick(116);
    c.abs_req <= 1'h0;
    tick(10);
    $display("test absolute request ended");
    end_of_test();
  end
endmodule
